// ### gpp_consts.vh
// ============================================================================
// gpp constants
// ============================================================================
// register indices, field layouts, reset values and sense codes of the port.
// assumes a 32-bit register bus where byte address = 4 * register index.
`ifndef GPP_CONSTS_VH
`define GPP_CONSTS_VH

// ============================================================================
// widths
// ============================================================================
`define GPP_NPINS        8
`define GPP_SENSE_W      3
`define GPP_SENSE_ALL_W  24
`define GPP_IDX_W        6
`define GPP_DATA_W       32

// ============================================================================
// register indices (byte address is index times four)
// ============================================================================
`define GPP_IDX_DIR      6'h00
`define GPP_IDX_OUT      6'h04
`define GPP_IDX_OUT_SET  6'h05
`define GPP_IDX_OUT_CLR  6'h06
`define GPP_IDX_OUT_TGL  6'h07
`define GPP_IDX_IN       6'h08
`define GPP_IDX_FLAGS    6'h09
`define GPP_IDX_SENSE    6'h10
`define GPP_IDX_IRQCLR   6'h11
`define GPP_IDX_IRQEN    6'h12

// ============================================================================
// reset values
// ============================================================================
`define GPP_RST_BYTE     8'h00
`define GPP_RST_SENSE    24'h000000
`define GPP_RST_WORD     32'h00000000
`define GPP_OE_N_RST     8'hff

// ============================================================================
// sense configuration codes
// ============================================================================
`define GPP_SENSE_INTOFF 3'h0
`define GPP_SENSE_BOTH   3'h1
`define GPP_SENSE_RISE   3'h2
`define GPP_SENSE_FALL   3'h3
`define GPP_SENSE_INOFF  3'h4
`define GPP_SENSE_LOW    3'h5

// ============================================================================
// bus encodings
// ============================================================================
`define GPP_HTRANS_NONSEQ_BIT 1
`define GPP_HIGH_ADDR_ZERO    24'h000000

`endif

// ### gpp_pin_ext.sv
// gpp_pin_ext: outside circuits on the eight port pins
// assumes the outside drives every pin through a resistor
`include "gpp_consts.vh"
// ==========
// pin level
module gpp_pin_ext
(
	input  wire [`GPP_NPINS-1:0] pin_o,
	input  wire [`GPP_NPINS-1:0] pin_oe_n_o,
	input  wire [`GPP_NPINS-1:0] ext_val_i,
	output wire [`GPP_NPINS-1:0] pin_lvl_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// device driver wins while enabled
	assign pin_lvl_o = (~pin_oe_n_o & pin_o) | (pin_oe_n_o & ext_val_i);
endmodule // gpp_pin_ext

// ### gpp_port.v
// ============================================================================
// gpp_port: eight-pin port with output, alias, input and event flag registers
// ============================================================================
// assumes a single AHB-Lite master, single word transfers, and pins wired
// outside through a tristate buffer that drives while pin_oe_n_o is low.
//
// Functional notes
// - output bit 0 drives low, 1 high
// - level reaches pin only when driver enabled
// - set alias sets bits written one
// - clear alias clears bits written one
// - toggle alias inverts bits written one
// - alias reads return output level register
// - input register shows sampled enabled pins
// - input bit low reads 0, high 1
// - disabled input buffer holds last value
// - writing one to input toggles output
// - flag sets when pin matches sense
// - writing one to flag clears it
// - code 4 disables buffer, 0 interrupt
// - direction one enables driver, zero input
//
// Chosen here: the AHB-Lite register port.
`include "gpp_consts.vh"
module gpp_port
(
	input  wire                     clk_sys_i,
	input  wire                     rst_i,
	// ahb-lite slave
	input  wire                     hsel_i,
	input  wire [31:0]              haddr_i,
	input  wire [1:0]               htrans_i,
	input  wire                     hwrite_i,
	input  wire [2:0]               hsize_i,
	input  wire [31:0]              hwdata_i,
	input  wire                     hready_i,
	output wire [31:0]              hrdata_o,
	output wire                     hreadyout_o,
	output wire                     hresp_o,
	// pins
	input  wire [`GPP_NPINS-1:0]    pin_i,
	output wire [`GPP_NPINS-1:0]    pin_o,
	output wire [`GPP_NPINS-1:0]    pin_oe_n_o,
	// interrupt
	output wire                     irq_o
);

	// ========================================================================
	// bus state machine states
	// ========================================================================
	localparam ST_IDLE = 1'b0;
	localparam ST_READ = 1'b1;

	// ========================================================================
	// declarations
	// ========================================================================
	reg                         state_q;
	reg                         state_d;
	reg                         wr_pend_q;
	reg  [`GPP_IDX_W-1:0]       idx_q;
	reg                         hit_q;
	reg  [31:0]                 hrdata_q;
	reg                         hready_q;
	reg                         hresp_q;
	reg  [`GPP_NPINS-1:0]       dir_q;
	reg  [`GPP_NPINS-1:0]       dir_d;
	reg  [`GPP_NPINS-1:0]       oe_n_q;
	reg  [`GPP_NPINS-1:0]       out_q;
	reg  [`GPP_NPINS-1:0]       out_d;
	reg  [`GPP_NPINS-1:0]       pin_q;
	reg  [`GPP_NPINS-1:0]       in_q;
	reg  [`GPP_NPINS-1:0]       in_d;
	reg  [`GPP_SENSE_ALL_W-1:0] sense_q;
	reg  [`GPP_SENSE_ALL_W-1:0] sense_d;
	reg  [`GPP_NPINS-1:0]       flags_q;
	reg  [`GPP_NPINS-1:0]       flags_d;
	reg  [`GPP_NPINS-1:0]       flag_clr;
	reg  [`GPP_NPINS-1:0]       irqen_q;
	reg  [`GPP_NPINS-1:0]       irqen_d;
	reg                         irq_q;
	wire                        accept;
	wire                        addr_ok;
	wire [`GPP_NPINS-1:0]       pin_sync;
	wire [`GPP_NPINS-1:0]       pin_event;
	wire [`GPP_NPINS-1:0]       in_en;
	wire [`GPP_NPINS-1:0]       wbyte;

	// ========================================================================
	// helpers
	// ========================================================================
	// true when the captured index selects a given register
	function sel;
		input                  hit;
		input [`GPP_IDX_W-1:0] idx;
		input [`GPP_IDX_W-1:0] reg_idx;
		begin
			sel = hit & (idx == reg_idx);
		end
	endfunction

	// ========================================================================
	// pin input path
	// ========================================================================
	gpp_sync u_sync
	(
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.async_i   (pin_i),
		.sync_o    (pin_sync)
	);

	gpp_sense u_sense
	(
		.clk_sys_i   (clk_sys_i),
		.rst_i       (rst_i),
		.pins_i      (pin_sync),
		.sense_cfg_i (sense_q),
		.event_o     (pin_event)
	);

	// input buffer enabled unless the pin's code is input-off
	genvar n;
	generate
		for (n = 0; n < `GPP_NPINS; n = n + 1)
		begin : g_inen
			assign in_en[n] = (sense_q[n*`GPP_SENSE_W +: `GPP_SENSE_W] != `GPP_SENSE_INOFF);
		end
	endgenerate

	// ========================================================================
	// bus address phase
	// ========================================================================
	assign accept  = hsel_i & hready_i & htrans_i[`GPP_HTRANS_NONSEQ_BIT];
	assign addr_ok = (haddr_i[31:8] == `GPP_HIGH_ADDR_ZERO);
	assign wbyte   = hwdata_i[`GPP_NPINS-1:0];

	// read takes one wait state so it sees a write just committed
	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (accept & ~hwrite_i)
					state_d = ST_READ;
			ST_READ:
				state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	// capture address phase and drive bus answer flops
	always @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			state_q   <= ST_IDLE;
			wr_pend_q <= 1'b0;
			idx_q     <= `GPP_IDX_DIR;
			hit_q     <= 1'b0;
			hrdata_q  <= `GPP_RST_WORD;
			hready_q  <= 1'b1;
			hresp_q   <= 1'b0;
		end
		else
		begin
			state_q   <= state_d;
			wr_pend_q <= accept & hwrite_i;
			if (accept)
			begin
				idx_q <= haddr_i[`GPP_IDX_W+1:2];
				hit_q <= addr_ok;
			end
			hready_q <= ~(state_q == ST_IDLE && accept && !hwrite_i);
			hresp_q  <= 1'b0; // always okay
			if (state_q == ST_READ)
				hrdata_q <= read_word(hit_q, idx_q);
		end
	end

	// read mux; unmapped and write-only registers read zero
	function [31:0] read_word;
		input                  hit;
		input [`GPP_IDX_W-1:0] idx;
		begin
			if (sel(hit, idx, `GPP_IDX_DIR))
				read_word = {24'h000000, dir_q};
			else if (sel(hit, idx, `GPP_IDX_OUT) | sel(hit, idx, `GPP_IDX_OUT_SET) |
			         sel(hit, idx, `GPP_IDX_OUT_CLR) | sel(hit, idx, `GPP_IDX_OUT_TGL))
				read_word = {24'h000000, out_q};
			else if (sel(hit, idx, `GPP_IDX_IN))
				read_word = {24'h000000, in_q};
			else if (sel(hit, idx, `GPP_IDX_FLAGS))
				read_word = {24'h000000, flags_q};
			else if (sel(hit, idx, `GPP_IDX_SENSE))
				read_word = {8'h00, sense_q};
			else if (sel(hit, idx, `GPP_IDX_IRQEN))
				read_word = {24'h000000, irqen_q};
			else
				read_word = `GPP_RST_WORD;
		end
	endfunction

	// ========================================================================
	// register next values (writes apply in data phase)
	// ========================================================================
	always @*
	begin
		dir_d    = dir_q;
		out_d    = out_q;
		sense_d  = sense_q;
		irqen_d  = irqen_q;
		flag_clr = `GPP_RST_BYTE;
		if (wr_pend_q)
		begin
			if (sel(hit_q, idx_q, `GPP_IDX_DIR))
				dir_d = wbyte;
			else if (sel(hit_q, idx_q, `GPP_IDX_OUT))
				out_d = wbyte;
			else if (sel(hit_q, idx_q, `GPP_IDX_OUT_SET))
				out_d = out_q | wbyte;
			else if (sel(hit_q, idx_q, `GPP_IDX_OUT_CLR))
				out_d = out_q & ~wbyte;
			else if (sel(hit_q, idx_q, `GPP_IDX_OUT_TGL))
				out_d = out_q ^ wbyte;
			else if (sel(hit_q, idx_q, `GPP_IDX_IN))
				out_d = out_q ^ wbyte;
			else if (sel(hit_q, idx_q, `GPP_IDX_FLAGS) | sel(hit_q, idx_q, `GPP_IDX_IRQCLR))
				flag_clr = wbyte;
			else if (sel(hit_q, idx_q, `GPP_IDX_SENSE))
				sense_d = hwdata_i[`GPP_SENSE_ALL_W-1:0];
			else if (sel(hit_q, idx_q, `GPP_IDX_IRQEN))
				irqen_d = wbyte;
		end
	end

	// sampled input holds while its buffer is off; writes never touch it
	always @*
	begin
		in_d = (pin_sync & in_en) | (in_q & ~in_en);
	end

	// a new event wins over a clear in the same cycle
	always @*
	begin
		flags_d = (flags_q & ~flag_clr) | pin_event;
	end

	// ========================================================================
	// state registers
	// ========================================================================
	always @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			dir_q   <= `GPP_RST_BYTE;
			oe_n_q  <= `GPP_OE_N_RST;
			out_q   <= `GPP_RST_BYTE;
			pin_q   <= `GPP_RST_BYTE;
			in_q    <= `GPP_RST_BYTE;
			sense_q <= `GPP_RST_SENSE;
			flags_q <= `GPP_RST_BYTE;
			irqen_q <= `GPP_RST_BYTE;
			irq_q   <= 1'b0;
		end
		else
		begin
			dir_q   <= dir_d;
			oe_n_q  <= ~dir_d;
			out_q   <= out_d;
			pin_q   <= out_d;
			in_q    <= in_d;
			sense_q <= sense_d;
			flags_q <= flags_d;
			irqen_q <= irqen_d;
			irq_q   <= |(flags_d & irqen_d);
		end
	end

	// ========================================================================
	// outputs
	// ========================================================================
	assign hrdata_o    = hrdata_q;
	assign hreadyout_o = hready_q;
	assign hresp_o     = hresp_q;
	assign pin_o       = pin_q;
	assign pin_oe_n_o  = oe_n_q;
	assign irq_o       = irq_q;

endmodule // gpp_port

// ### gpp_port_assertions.sv
// gpp_chk: bus timing and register effect checks on gpp_port ports
// assumes one master with hready_i tied to hreadyout_o
`include "gpp_consts.vh"
// ==========
// checker
module gpp_chk
(
	input wire                  clk_sys_i,
	input wire                  rst_i,
	input wire                  hsel_i,
	input wire [31:0]           haddr_i,
	input wire [1:0]            htrans_i,
	input wire                  hwrite_i,
	input wire [2:0]            hsize_i,
	input wire [31:0]           hwdata_i,
	input wire                  hready_i,
	input wire [31:0]           hrdata_o,
	input wire                  hreadyout_o,
	input wire                  hresp_o,
	input wire [`GPP_NPINS-1:0] pin_i,
	input wire [`GPP_NPINS-1:0] pin_o,
	input wire [`GPP_NPINS-1:0] pin_oe_n_o,
	input wire                  irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic                  take_w;
	logic [7:0]            wd_w;
	logic                  wr_q;
	logic                  rd_q;
	logic [`GPP_IDX_W-1:0] idx_q;
	assign take_w = hsel_i & hready_i & htrans_i[1];
	assign wd_w = hwdata_i[7:0];
	// data phase tracking, nonzero haddr_i[31:8] seen as 3f
	always @(posedge clk_sys_i)
	begin
		wr_q <= ~rst_i & take_w & hwrite_i;
		rd_q <= ~rst_i & take_w & ~hwrite_i;
		if (take_w)
			idx_q <= (haddr_i[31:8] != 24'h0) ? 6'h3f : haddr_i[7:2];
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	chk_bus_okay: assert property (hresp_o == 1'b0)
		else $error("bus response not okay");
	chk_write_nowait: assert property (take_w && hwrite_i |=> hreadyout_o)
		else $error("write stalled");
	chk_read_wait: assert property (take_w && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait wrong");
	chk_set_alias: assert property (wr_q && idx_q == `GPP_IDX_OUT_SET
		|=> pin_o == ($past(pin_o) | $past(wd_w))) else $error("set alias wrong");
	chk_clr_alias: assert property (wr_q && idx_q == `GPP_IDX_OUT_CLR
		|=> pin_o == ($past(pin_o) & ~$past(wd_w))) else $error("clear alias wrong");
	chk_tgl_alias: assert property (wr_q && idx_q == `GPP_IDX_OUT_TGL
		|=> pin_o == ($past(pin_o) ^ $past(wd_w))) else $error("toggle alias wrong");
	chk_in_toggle: assert property (wr_q && idx_q == `GPP_IDX_IN
		|=> pin_o == ($past(pin_o) ^ $past(wd_w))) else $error("input write wrong");
	chk_alias_read: assert property (rd_q && idx_q inside {`GPP_IDX_OUT_SET, `GPP_IDX_OUT_CLR, `GPP_IDX_OUT_TGL}
		|=> hrdata_o == {24'h0, pin_o}) else $error("alias read wrong");
	chk_out_by_write: assert property ($changed(pin_o) |-> $past(wr_q))
		else $error("output moved without write");
	chk_dir_by_write: assert property ($changed(pin_oe_n_o) |-> $past(wr_q))
		else $error("enable moved without write");
endmodule // gpp_chk

bind gpp_port gpp_chk chk_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
	.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pin_i(pin_i), .pin_o(pin_o),
	.pin_oe_n_o(pin_oe_n_o), .irq_o(irq_o));

// ### gpp_sense.v
// ============================================================================
// gpp_sense: per-pin edge and level sense detection
// ============================================================================
// assumes pins_i is already synchronised to clk_sys_i.
`include "gpp_consts.vh"
module gpp_sense
(
	input  wire                        clk_sys_i,
	input  wire                        rst_i,
	input  wire [`GPP_NPINS-1:0]       pins_i,
	input  wire [`GPP_SENSE_ALL_W-1:0] sense_cfg_i,
	output wire [`GPP_NPINS-1:0]       event_o
);

	reg  [`GPP_NPINS-1:0] prev_q;
	wire [`GPP_NPINS-1:0] rise;
	wire [`GPP_NPINS-1:0] fall;

	// previous synchronised level for edge detection
	always @(posedge clk_sys_i)
	begin
		if (rst_i)
			prev_q <= `GPP_RST_BYTE;
		else
			prev_q <= pins_i;
	end

	assign rise = pins_i & ~prev_q;
	assign fall = ~pins_i & prev_q;

	// match each pin against its own sense code
	genvar n;
	generate
		for (n = 0; n < `GPP_NPINS; n = n + 1)
		begin : g_pin
			wire [`GPP_SENSE_W-1:0] code;
			assign code = sense_cfg_i[n*`GPP_SENSE_W +: `GPP_SENSE_W];
			// off and input-off codes never match
			assign event_o[n] =
				((code == `GPP_SENSE_BOTH) & (rise[n] | fall[n])) |
				((code == `GPP_SENSE_RISE) & rise[n]) |
				((code == `GPP_SENSE_FALL) & fall[n]) |
				((code == `GPP_SENSE_LOW)  & ~pins_i[n]);
		end
	endgenerate

endmodule // gpp_sense

// ### gpp_sync.v
// ============================================================================
// gpp_sync: two-flop synchroniser for the pin inputs
// ============================================================================
// assumes pin levels are asynchronous to clk_sys_i.
`include "gpp_consts.vh"
module gpp_sync
(
	input  wire                     clk_sys_i,
	input  wire                     rst_i,
	input  wire [`GPP_NPINS-1:0]    async_i,
	output wire [`GPP_NPINS-1:0]    sync_o
);

	reg [`GPP_NPINS-1:0] meta_q;
	reg [`GPP_NPINS-1:0] sync_q;

	// first stage read only by the second stage
	always @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			meta_q <= `GPP_RST_BYTE;
			sync_q <= `GPP_RST_BYTE;
		end
		else
		begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule // gpp_sync

// ### testbench.sv
// testbench: register bus sequences against gpp_port
// assumes one clock at 200 MHz and the outside model on the pins
`include "gpp_consts.vh"
// ==========
// bench
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0]  ext = 8'h00;
	logic [5:0]  i;
	wire  [31:0] hrdata;
	wire         hready;
	wire         hresp;
	wire  [7:0]  pin_lvl;
	wire  [7:0]  pin_o;
	wire  [7:0]  pin_oe_n;
	wire         irq;
	integer      fails = 0;
	integer      cmp_count = 0;
	gpp_port dut_u (.clk_sys_i(clk), .rst_i(rst), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp), .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n),
		.irq_o(irq));
	gpp_pin_ext ext_u (.pin_o(pin_o), .pin_oe_n_o(pin_oe_n), .ext_val_i(ext), .pin_lvl_o(pin_lvl));
	// 5 ns clock
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
	begin
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	end
	endtask
	task end_of_test;
	begin
		$display("fails %0d cmp_count %0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	task idle(input integer n);
	begin
		repeat (n) @(posedge clk);
	end
	endtask
	// bounded wait for hready at a rising edge
	task hwait;
		integer n;
	begin
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (hready === 1'b1)
				break;
		end
		if (n == 50)
		begin
			fails++;
			end_of_test;
		end
	end
	endtask
	task wr(input logic [5:0] idx, input logic [31:0] d);
	begin
		htrans <= 2'h2;
		haddr <= {24'h0, idx, 2'h0};
		hwrite <= 1'b1;
		hwait;
		htrans <= 2'h0;
		hwdata <= d;
		hwait;
	end
	endtask
	task rchk(input string nm, input logic [5:0] idx, input logic [31:0] exp);
	begin
		htrans <= 2'h2;
		haddr <= {24'h0, idx, 2'h0};
		hwrite <= 1'b0;
		hwait;
		htrans <= 2'h0;
		hwait;
		chk(nm, hrdata, exp);
	end
	endtask
	// main sequence
	initial
	begin
		idle(4);
		rst <= 1'b0;
		idle(1);
		chk("oe_rst", {24'h0, pin_oe_n}, 32'hff);
		for (i = 6'h04; i < 6'h0a; i++)
			rchk("reset", i, 32'h0);
		wr(`GPP_IDX_OUT, 32'h3c);
		wr(`GPP_IDX_OUT_SET, 32'h81);
		rchk("set", `GPP_IDX_OUT_SET, 32'hbd);
		wr(`GPP_IDX_OUT_CLR, 32'h0c);
		rchk("clr", `GPP_IDX_OUT_CLR, 32'hb1);
		wr(`GPP_IDX_OUT_TGL, 32'hff);
		rchk("tgl", `GPP_IDX_OUT_TGL, 32'h4e);
		wr(`GPP_IDX_IN, 32'h03);
		rchk("in_wr", `GPP_IDX_OUT, 32'h4d);
		rchk("in_keep", `GPP_IDX_IN, 32'h0);
		chk("pin_o", {24'h0, pin_o}, 32'h4d);
		ext <= 8'haa;
		wr(`GPP_IDX_DIR, 32'h0f);
		idle(4);
		chk("oe", {24'h0, pin_oe_n}, 32'hf0);
		rchk("in", `GPP_IDX_IN, 32'had);
		wr(`GPP_IDX_DIR, 32'h0);
		wr(`GPP_IDX_SENSE, {8'h0, 3'h0, 3'h0, `GPP_SENSE_LOW, `GPP_SENSE_INOFF, `GPP_SENSE_FALL,
			`GPP_SENSE_RISE, `GPP_SENSE_BOTH, `GPP_SENSE_INTOFF});
		idle(4);
		wr(`GPP_IDX_FLAGS, 32'hff);
		rchk("flags0", `GPP_IDX_FLAGS, 32'h0);
		ext <= 8'h55;
		idle(4);
		rchk("flags", `GPP_IDX_FLAGS, 32'h2e);
		rchk("hold", `GPP_IDX_IN, 32'h45);
		wr(`GPP_IDX_FLAGS, 32'h0);
		rchk("w0", `GPP_IDX_FLAGS, 32'h2e);
		wr(`GPP_IDX_IRQEN, 32'h02);
		idle(1);
		chk("irq_on", {31'h0, irq}, 32'h1);
		wr(`GPP_IDX_FLAGS, 32'h02);
		idle(1);
		chk("irq_off", {31'h0, irq}, 32'h0);
		rchk("w1c", `GPP_IDX_FLAGS, 32'h2c);
		wr(`GPP_IDX_IRQEN, 32'h20);
		wr(`GPP_IDX_IRQCLR, 32'h20);
		idle(1);
		chk("irq_lvl", {31'h0, irq}, 32'h1);
		rchk("irqclr", `GPP_IDX_IRQCLR, 32'h0);
		wr(`GPP_IDX_IRQEN, 32'h0);
		idle(1);
		chk("irq_mask", {31'h0, irq}, 32'h0);
		wr(`GPP_IDX_FLAGS, 32'hff);
		ext <= 8'haa;
		idle(4);
		rchk("back", `GPP_IDX_FLAGS, 32'h22);
		wr(6'h0f, 32'hff);
		rchk("unmapped", 6'h0f, 32'h0);
		end_of_test;
	end
endmodule // testbench
